//--- pbl_pkg.sv
`default_nettype none
package pbl_pkg;
	// Pll ratio settings per mode pin pair
	localparam logic [1:0] MODE_R40 = 2'h0;
	localparam logic [1:0] MODE_R4 = 2'h1;
	localparam logic [1:0] MODE_R8 = 2'h2;
	localparam logic [1:0] MODE_R16 = 2'h3;
	localparam logic [11:0] MULT_R40 = 12'h09F;
	localparam logic [11:0] MULT_R16 = 12'h03F;
	localparam logic [11:0] MULT_R8 = 12'h01F;
	localparam logic [11:0] MULT_R4 = 12'h00F;
	localparam logic [2:0] BOOT_OUT_DIV = 3'h1;
	localparam logic [5:0] BOOT_IN_SCALE = 6'h00;
	localparam int SEC_BOOT_BIT = 5;
	localparam logic [31:0] CRC_BYPASS = 32'h0D15AB1E;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [15:0] OTP_START = 16'h0000;
	localparam logic [17:0] RAM_BASE = 18'h00000;
	// Internal reset sequence after release, least figure
	localparam int RST_SEQ_NS = 15000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		PBL_SEQ, PBL_SECREQ, PBL_SECWAIT, PBL_LEN, PBL_PROG, PBL_CRC,
		PBL_CHECK, PBL_RUN, PBL_FAIL
	} pbl_state_t;
endpackage : pbl_pkg
`default_nettype wire

//--- pbl_crc_byte.sv
`timescale 1ns/1ps
`default_nettype none
module pbl_crc_byte (
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data,
	output logic [31:0] crc_out
);
	import pbl_pkg::*;
	always_comb begin
		logic [31:0] c;
		c = crc_in ^ {24'h000000, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		crc_out = c;
	end
endmodule : pbl_crc_byte
`default_nettype wire

//--- pbl_loader.sv
// Notes on behaviour
// - Mode pins select boot multiplier 159/63/31/15, output divide 1, in scale 0.
// - Tile clock is osc times (mult+1)/2 over (scale+1) over (divide+1).
// - Software may rewrite the three PLL values at run time.
// - While reset is low, tile held in reset and GPIO pull-downs on.
// - Boot begins 15 to 150 us after reset release.
// - Security bit 5 set boots from OTP, else from flash.
// - Image is word count, count times four bytes, then CRC word.
// - CRC field 0x0D15AB1E skips the check.
// - Count and CRC fields arrive least significant byte first.
// - Program bytes go to RAM from lowest address; run starts there.
// - CRC covers count bytes and program bytes, not the CRC field.
// - CRC uses reflected polynomial 0xEDB88320.
// - PLL output feeds switch, tile and reference clocks.
// - Secure boot loads from OTP address 0, bypassing boot ROM.
// - Security register loaded from OTP in the same cycle as the source is chosen.
`timescale 1ns/1ps
`default_nettype none
module pbl_loader #(
	parameter int RST_SEQ = pbl_pkg::RST_SEQ_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] mode_pin,
	// Run-time PLL write
	input wire logic pll_wr,
	input wire logic [11:0] pll_mult_wdata,
	input wire logic [5:0] pll_scale_wdata,
	input wire logic [2:0] pll_div_wdata,
	output logic [11:0] loop_multiplier,
	output logic [5:0] in_scale,
	output logic [2:0] output_divide,
	output logic gpio_pulldown,
	output logic tile_reset_n,
	// Security word from OTP
	output logic sec_rd_req,
	input wire logic sec_rd_valid,
	input wire logic [31:0] sec_rd_data,
	output logic [31:0] security_word,
	// Byte source selection and stream
	output logic src_otp,
	output logic [15:0] otp_start_addr,
	output logic src_ready,
	input wire logic src_valid,
	input wire logic [7:0] src_byte,
	// RAM write port
	output logic ram_we,
	output logic [17:0] ram_addr,
	output logic [7:0] ram_wdata,
	output logic run,
	output logic [17:0] run_addr,
	output logic boot_fail
);
	import pbl_pkg::*;
	logic [1:0] mode_s1_q, mode_s2_q;
	pbl_state_t state_q;
	logic [$clog2(RST_SEQ+1)-1:0] seq_q;
	logic [1:0] bcnt_q;
	logic [31:0] word_q, count_q, crc_q, crc_nx;
	logic [31:0] left_q;
	logic take;
	logic [31:0] wnext;

	assign take = src_ready && src_valid;
	assign wnext = {src_byte, word_q[31:8]};
	assign src_ready = (state_q == PBL_LEN) || (state_q == PBL_PROG) || (state_q == PBL_CRC);
	assign gpio_pulldown = ~rst_n;
	assign sec_rd_req = (state_q == PBL_SECREQ);
	assign otp_start_addr = OTP_START;
	assign run_addr = RAM_BASE;

	pbl_crc_byte u_crc (
		.crc_in(crc_q),
		.data(src_byte),
		.crc_out(crc_nx)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_s1_q <= 2'h0;
			mode_s2_q <= 2'h0;
		end else begin
			mode_s1_q <= mode_pin;
			mode_s2_q <= mode_s1_q;
		end
	end

	// PLL values: boot table from mode pins, then software writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_multiplier <= MULT_R40;
			in_scale <= BOOT_IN_SCALE;
			output_divide <= BOOT_OUT_DIV;
		end else if (state_q == PBL_SEQ) begin
			case (mode_s2_q)
				MODE_R40: loop_multiplier <= MULT_R40;
				MODE_R16: loop_multiplier <= MULT_R16;
				MODE_R8: loop_multiplier <= MULT_R8;
				default: loop_multiplier <= MULT_R4;
			endcase
			in_scale <= BOOT_IN_SCALE;
			output_divide <= BOOT_OUT_DIV;
		end else if (pll_wr) begin
			loop_multiplier <= pll_mult_wdata;
			in_scale <= pll_scale_wdata;
			output_divide <= pll_div_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_q <= '0;
		end else if (state_q == PBL_SEQ) begin
			seq_q <= seq_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			security_word <= 32'h00000000;
			src_otp <= 1'b0;
		end else if (state_q == PBL_SECWAIT && sec_rd_valid) begin
			security_word <= sec_rd_data;
			src_otp <= sec_rd_data[SEC_BOOT_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= PBL_SEQ;
			bcnt_q <= 2'h0;
			word_q <= 32'h00000000;
			count_q <= 32'h00000000;
			left_q <= 32'h00000000;
			crc_q <= CRC_INIT;
		end else begin
			case (state_q)
				PBL_SEQ: begin
					if (seq_q == ($clog2(RST_SEQ+1))'(RST_SEQ - 1)) begin
						state_q <= PBL_SECREQ;
					end
				end
				PBL_SECREQ: state_q <= PBL_SECWAIT;
				PBL_SECWAIT: begin
					if (sec_rd_valid) begin
						state_q <= PBL_LEN;
					end
				end
				PBL_LEN, PBL_PROG, PBL_CRC: begin
					if (take) begin
						bcnt_q <= bcnt_q + 1'b1;
						word_q <= wnext;
						if (state_q != PBL_CRC) begin
							crc_q <= crc_nx;
						end
						if (state_q == PBL_PROG && bcnt_q == 2'h3) begin
							left_q <= left_q - 32'h1;
						end
						if (bcnt_q == 2'h3) begin
							if (state_q == PBL_LEN) begin
								count_q <= wnext;
								left_q <= wnext;
								state_q <= (wnext == 32'h0) ? PBL_CRC : PBL_PROG;
							end else if (state_q == PBL_PROG) begin
								if (left_q == 32'h1) begin
									state_q <= PBL_CRC;
								end
							end else begin
								state_q <= PBL_CHECK;
							end
						end
					end
				end
				PBL_CHECK: begin
					if (word_q == CRC_BYPASS || word_q == ~crc_q) begin
						state_q <= PBL_RUN;
					end else begin
						state_q <= PBL_FAIL;
					end
				end
				PBL_RUN: state_q <= PBL_RUN;
				PBL_FAIL: state_q <= PBL_FAIL;
				default: state_q <= PBL_FAIL;
			endcase
		end
	end

	// RAM write address walks up from the base
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ram_we <= 1'b0;
			ram_addr <= RAM_BASE;
			ram_wdata <= 8'h00;
		end else begin
			ram_we <= take && state_q == PBL_PROG;
			ram_wdata <= src_byte;
			if (ram_we) begin
				ram_addr <= ram_addr + 18'h00001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= 1'b0;
			boot_fail <= 1'b0;
			tile_reset_n <= 1'b0;
		end else begin
			run <= (state_q == PBL_RUN);
			boot_fail <= (state_q == PBL_FAIL);
			tile_reset_n <= (state_q != PBL_SEQ);
		end
	end

	chk_boot_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(state_q == PBL_SEQ) |-> $past(seq_q) == ($clog2(RST_SEQ+1))'(RST_SEQ - 1))
		else $error("boot left reset sequence early");
	chk_bypass_run: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == PBL_CHECK && word_q == CRC_BYPASS |=> state_q == PBL_RUN ##1 run)
		else $error("bypass value did not start program");
	chk_bad_crc: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == PBL_CHECK && word_q != CRC_BYPASS && word_q != ~crc_q |=> ##1 !run [*3])
		else $error("bad crc started program");
	chk_src_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == PBL_SECWAIT && sec_rd_valid |=> src_otp == $past(sec_rd_data[SEC_BOOT_BIT]))
		else $error("boot source mismatch");
	chk_ram_order: assert property (@(posedge core_clk) disable iff (!rst_n)
		ram_we |=> ram_addr == $past(ram_addr) + 18'h00001)
		else $error("ram address not ascending");
	chk_mode_ratio: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == PBL_SEQ && mode_s2_q == MODE_R8 |=> loop_multiplier == MULT_R8)
		else $error("boot multiplier wrong");
	chk_pll_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q != PBL_SEQ && pll_wr |=> output_divide == $past(pll_div_wdata))
		else $error("pll write lost");
	chk_crc_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_q == PBL_CRC && take |=> $stable(crc_q))
		else $error("crc field entered checksum");
	chk_pulldown: assert property (@(posedge core_clk)
		!rst_n |-> gpio_pulldown && !tile_reset_n && !run)
		else $error("pulldown missing in reset");
	cov_run: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(run));
	cov_fail: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(boot_fail));
	cov_otp: cover property (@(posedge core_clk) disable iff (!rst_n) src_otp && ram_we);
endmodule : pbl_loader
`default_nettype wire

//--- pbl_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbl_src_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [31:0] sec_word,
	input wire logic sec_rd_req,
	output logic sec_rd_valid,
	output logic [31:0] sec_rd_data,
	input wire logic src_ready,
	output logic src_valid,
	output logic [7:0] src_byte
);
	logic [7:0] img [0:63];
	int n_bytes;
	int idx;
	initial begin
		sec_rd_valid = 1'b0;
		src_valid = 1'b0;
		sec_rd_data = 32'h0;
		src_byte = 8'h0;
	end
	// Released lines change every cycle (inverted or stepped), so stale bytes are not held
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx <= 0;
			sec_rd_valid <= 1'b0;
			src_valid <= 1'b0;
		end else begin
			sec_rd_valid <= sec_rd_req;
			sec_rd_data <= sec_rd_req ? sec_word : ~sec_rd_data;
			if (src_valid && src_ready) begin
				idx <= idx + 1;
				src_valid <= !slow && idx + 1 < n_bytes;
				src_byte <= (!slow && idx + 1 < n_bytes) ? img[idx + 1] : ~src_byte;
			end else if (!src_valid && idx < n_bytes) begin
				src_valid <= 1'b1;
				src_byte <= img[idx];
			end else if (!src_valid) begin
				src_byte <= src_byte + 8'h3B;
			end
		end
	end
endmodule : pbl_src_model
`default_nettype wire

//--- test_pll_setup_and_boot_loader.sv
`timescale 1ns/1ps
`default_nettype none
module test_pll_setup_and_boot_loader;
	import pbl_pkg::*;
	typedef struct {logic [1:0] md; logic sec; int cnt; logic byp; logic bad; logic slw;
		logic [11:0] mul;} pbl_row_t;
	pbl_row_t rows [4] = '{'{2'h0, 1'b0, 2, 1'b0, 1'b0, 1'b0, MULT_R40},
		'{2'h3, 1'b1, 0, 1'b0, 1'b0, 1'b1, MULT_R16}, '{2'h2, 1'b0, 1, 1'b1, 1'b0, 1'b0, MULT_R8},
		'{2'h1, 1'b1, 3, 1'b0, 1'b1, 1'b1, MULT_R4}};
	logic core_clk = 1'b0, rst_n = 1'b0, pll_wr = 1'b0, slow = 1'b0;
	logic [1:0] mode_pin = 2'h0;
	logic [11:0] pll_mult_w = 12'h123;
	logic [5:0] pll_scale_w = 6'h05;
	logic [2:0] pll_div_w = 3'h3;
	logic [31:0] sec_w = 32'h0, sec_rd_data, security_word;
	logic sec_rd_req, sec_rd_valid, src_ready, src_valid, src_otp, ram_we, run, boot_fail;
	logic gpio_pulldown, tile_reset_n;
	logic [11:0] loop_multiplier;
	logic [5:0] in_scale;
	logic [2:0] output_divide;
	logic [7:0] src_byte, ram_wdata;
	logic [15:0] otp_start_addr;
	logic [17:0] ram_addr, run_addr;
	logic [7:0] ram [0:63];
	int n_we, err_total = 0, n_checks = 0;
	pbl_loader #(.RST_SEQ(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .mode_pin(mode_pin),
		.pll_wr(pll_wr), .pll_mult_wdata(pll_mult_w), .pll_scale_wdata(pll_scale_w),
		.pll_div_wdata(pll_div_w), .loop_multiplier(loop_multiplier), .in_scale(in_scale),
		.output_divide(output_divide), .gpio_pulldown(gpio_pulldown),
		.tile_reset_n(tile_reset_n), .sec_rd_req(sec_rd_req), .sec_rd_valid(sec_rd_valid),
		.sec_rd_data(sec_rd_data), .security_word(security_word), .src_otp(src_otp),
		.otp_start_addr(otp_start_addr), .src_ready(src_ready), .src_valid(src_valid),
		.src_byte(src_byte), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.run(run), .run_addr(run_addr), .boot_fail(boot_fail));
	pbl_src_model m_u (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .sec_word(sec_w),
		.sec_rd_req(sec_rd_req), .sec_rd_valid(sec_rd_valid), .sec_rd_data(sec_rd_data),
		.src_ready(src_ready), .src_valid(src_valid), .src_byte(src_byte));
	initial forever #5 core_clk = ~core_clk;
	task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk_v
	task automatic chk_b(input string nm, input logic e, input logic s);
		chk_v(nm, {31'h0, e}, {31'h0, s});
	endtask : chk_b
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			n_we <= 0;
		end else if (ram_we === 1'b1) begin
			chk_v("ram_addr", 32'(n_we), 32'(ram_addr));
			ram[ram_addr[5:0]] <= ram_wdata;
			n_we <= n_we + 1;
		end
	end
	function automatic logic [31:0] crc_f(input int n);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 0; i < n; i++) begin
			c = c ^ {24'h0, m_u.img[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc_f
	task automatic load_img(input pbl_row_t r);
		logic [31:0] c;
		for (int i = 0; i < 4; i++) m_u.img[i] = 8'(r.cnt >> (8 * i));
		for (int i = 0; i < 4 * r.cnt; i++) m_u.img[4 + i] = 8'(i * 29 + 90);
		c = r.byp ? CRC_BYPASS : crc_f(4 + 4 * r.cnt) ^ {31'h0, r.bad};
		for (int i = 0; i < 4; i++) m_u.img[4 + 4 * r.cnt + i] = c[8 * i +: 8];
		m_u.n_bytes = 8 + 4 * r.cnt;
		slow = r.slw;
		sec_w = {26'h0, r.sec, 5'h0};
		rst_n = 1'b0;
		mode_pin = r.md;
		repeat (20) tick();
		chk_b("pulldown", 1'b1, gpio_pulldown);
		chk_b("tile_reset_n", 1'b0, tile_reset_n);
		rst_n = 1'b1;
		tick();
		chk_b("seq_hold", 1'b0, tile_reset_n || src_ready);
	endtask : load_img
	task automatic wait_for(input int lim);
		int k;
		k = 0;
		while (run !== 1'b1 && boot_fail !== 1'b1 && n_we < lim && k < 3000) begin
			tick();
			k++;
		end
		chk_b("timeout", 1'b0, k == 3000);
		if (k == 3000) end_of_test();
	endtask : wait_for
	initial begin
		foreach (rows[j]) begin
			load_img(rows[j]);
			wait_for(99);
			chk_v("mult", 32'(rows[j].mul), 32'(loop_multiplier));
			chk_b("tile_reset_n", 1'b1, tile_reset_n);
			chk_b("pulldown", 1'b0, gpio_pulldown);
			chk_v("div", 32'(BOOT_OUT_DIV), 32'(output_divide));
			chk_v("scale", 32'(BOOT_IN_SCALE), 32'(in_scale));
			chk_b("src_otp", rows[j].sec, src_otp);
			chk_v("otp_addr", 32'(OTP_START), 32'(otp_start_addr));
			chk_v("sec_word", sec_w, security_word);
			chk_b("run", ~rows[j].bad, run);
			chk_b("fail", rows[j].bad, boot_fail);
			chk_v("run_addr", 32'(RAM_BASE), 32'(run_addr));
			chk_v("n_we", 32'(4 * rows[j].cnt), 32'(n_we));
			for (int i = 0; i < 4 * rows[j].cnt; i++)
				chk_v("ram", 32'(m_u.img[4 + i]), 32'(ram[i]));
			$display("row %0d done", j);
		end
		pll_wr = 1'b1;
		tick();
		pll_wr = 1'b0;
		tick();
		chk_v("pll", 32'h0012302B, {8'h0, loop_multiplier, 3'h0, in_scale, output_divide});
		pll_mult_w = 12'hABC;
		pll_scale_w = 6'h3F;
		pll_div_w = 3'h7;
		pll_wr = 1'b1;
		tick();
		pll_wr = 1'b0;
		tick();
		chk_v("pll_max", 32'h00ABC1FF, {8'h0, loop_multiplier, 3'h0, in_scale, output_divide});
		$display("pll write done");
		load_img(rows[3]);
		wait_for(2);
		rst_n = 1'b0;
		#1;
		chk_b("pulldown", 1'b1, gpio_pulldown);
		chk_b("tile_reset_n", 1'b0, tile_reset_n);
		chk_b("run", 1'b0, run);
		$display("mid-load reset done");
		load_img(rows[0]);
		wait_for(99);
		chk_b("run_again", 1'b1, run);
		chk_v("n_we_again", 32'h00000008, 32'(n_we));
		chk_v("mult_again", 32'(MULT_R40), 32'(loop_multiplier));
		$display("reboot after reset done");
		end_of_test();
	end
endmodule : test_pll_setup_and_boot_loader
`default_nettype wire
